// >>> rtl/fbe_responder.sv
// Memory bit error responder: enables, sticky flags, reset and NMI requests, Wishbone slave.
//
// Overview of operation
// - Uncorrectable error resets only when reset enabled, records cause.
// - Uncorrectable NMI only when its enable set.
// - Correctable NMI only when its enable set.
// - Spurious fast-clock reset leaves cause zero, flag clear.
// - After wake, phantom errors act like real ones.
// - Reset enable zero blocks uncorrectable NMI entirely.
// - Uncorrectable detection sets the uncorrectable flag.
// - Spurious resets only with fast main clock.
`timescale 1ns/1ps
module fbe_responder
  import fbe_pkg::*;
#(
  parameter bit MODEL_DEFECTS = 1'b1 // Reproduce the known faulty behaviour of the silicon.
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Error detector and clock state.
  input  wire logic        uncorr_det,
  input  wire logic        corr_det,
  input  wire logic        glitch_det,
  input  wire logic        mclk_fast,
  input  wire logic        wake_pulse,
  input  wire logic        mem_access_done,
  // Responses to the reset and NMI controller.
  output logic             warm_system_reset,
  output logic             nmi_req,
  output logic      [7:0]  reset_cause_vector,
  output logic      [7:0]  system_nmi_vector,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  fbe_bus_t            bus_q, bus_d;         // Bus handshake state.
  logic [31:0]         rdat_q, rdat_d;       // Registered read data.
  logic [2:0]          ctrl_q, ctrl_d;       // mem_err_control_reg.
  logic [1:0]          flag_q, flag_d;       // mem_err_flag_reg.
  logic [7:0]          rstv_q, rstv_d;       // Reset cause vector.
  logic [7:0]          nmiv_q, nmiv_d;       // System NMI vector.
  logic [FBE_IRQ_W-1:0] irqs_q, irqs_d;      // Sticky interrupt status.
  logic [FBE_IRQ_W-1:0] irqm_q, irqm_d;      // Interrupt mask.
  logic                wake_q, wake_d;       // Post-wake window is open.
  logic                rst_q, rst_d;         // Warm reset request pulse.
  logic                nmi_q, nmi_d;         // NMI request pulse.

  // Decoded enables, for readability.
  logic uncorr_err_reset_en;
  logic uncorr_err_irq_en;
  logic corr_err_irq_en;
  assign uncorr_err_reset_en = ctrl_q[FBE_CTRL_RST_EN];
  assign uncorr_err_irq_en   = ctrl_q[FBE_CTRL_UIRQ_EN];
  assign corr_err_irq_en     = ctrl_q[FBE_CTRL_CIRQ_EN];

  // ----------------------------------------------------------------
  // Error classification.
  // ----------------------------------------------------------------
  logic uncorr_ev;   // Uncorrectable error taken as detected.
  logic silent_rst;  // Spurious reset that leaves no cause and no flag.
  logic uncorr_nmi;  // Uncorrectable NMI fires.
  logic corr_nmi;    // Correctable NMI fires.
  logic uncorr_rst;  // Recorded uncorrectable error reset.
  logic bus_wr;      // Write takes effect this edge.

  always_comb begin
    // A detector glitch inside the post-wake window looks exactly like a real error.
    uncorr_ev  = uncorr_det | (MODEL_DEFECTS & wake_q & glitch_det);
    // Outside that window the glitch only bites at a fast main clock, recording no cause and no flag.
    silent_rst = MODEL_DEFECTS & glitch_det & ~wake_q & mclk_fast
                 & uncorr_err_reset_en;
    uncorr_rst = uncorr_ev & uncorr_err_reset_en;
    // The silicon drops the uncorrectable NMI when the reset enable is low.
    uncorr_nmi = uncorr_ev & uncorr_err_irq_en
                 & (uncorr_err_reset_en | ~MODEL_DEFECTS);
    corr_nmi   = corr_det & corr_err_irq_en & ~uncorr_nmi;
    bus_wr     = (bus_q == FBE_BUS_ACK) & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  end

  // ----------------------------------------------------------------
  // Next-state logic for bus, registers and responses.
  // ----------------------------------------------------------------
  always_comb begin
    bus_d  = bus_q;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    flag_d = flag_q;
    rstv_d = rstv_q;
    nmiv_d = nmiv_q;
    irqs_d = irqs_q;
    irqm_d = irqm_q;
    wake_d = wake_q;
    // Handshake: ack one cycle after the strobe, then drop for one cycle.
    case (bus_q)
      FBE_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_d = FBE_BUS_ACK;
          case (wb_adr_i)
            FBE_ADDR_CTRL: rdat_d = {29'h0, ctrl_q};
            FBE_ADDR_FLAG: rdat_d = {30'h0, flag_q};
            FBE_ADDR_RSTV: rdat_d = {24'h0, rstv_q};
            FBE_ADDR_NMIV: rdat_d = {24'h0, nmiv_q};
            FBE_ADDR_IRQS: rdat_d = {28'h0, irqs_q};
            FBE_ADDR_IRQM: rdat_d = {28'h0, irqm_q};
            FBE_ADDR_STAT: rdat_d = {31'h0, wake_q};
            default:       rdat_d = 32'h0; // Unmapped reads as zero, still acked.
          endcase
        end
      end
      FBE_BUS_ACK: begin
        bus_d = FBE_BUS_IDLE;
      end
      default: begin
        bus_d = FBE_BUS_IDLE;
      end
    endcase
    // Software writes first, so that hardware events below override a clear.
    if (bus_wr) begin
      case (wb_adr_i)
        FBE_ADDR_CTRL: ctrl_d = wb_dat_i[2:0];
        FBE_ADDR_FLAG: flag_d = flag_q & ~wb_dat_i[1:0];
        FBE_ADDR_RSTV: rstv_d = FBE_VEC_NONE;
        FBE_ADDR_NMIV: nmiv_d = FBE_VEC_NONE;
        FBE_ADDR_IRQS: irqs_d = irqs_q & ~wb_dat_i[FBE_IRQ_W-1:0];
        FBE_ADDR_IRQM: irqm_d = wb_dat_i[FBE_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // Flags are sticky whatever the enables say; set wins over clear.
    if (uncorr_ev) begin
      flag_d[FBE_FLAG_UNCORR] = 1'b1;
      irqs_d[FBE_IRQ_UNCORR]  = 1'b1;
    end
    if (corr_det) begin
      flag_d[FBE_FLAG_CORR]  = 1'b1;
      irqs_d[FBE_IRQ_CORR]   = 1'b1;
    end
    // Reset causes: a real one is recorded, the spurious one leaves zero.
    if (uncorr_rst) begin
      rstv_d = FBE_RST_UNCOR;
      irqs_d[FBE_IRQ_RESET] = 1'b1;
    end else if (silent_rst) begin
      rstv_d = FBE_VEC_NONE;
      irqs_d[FBE_IRQ_RESET] = 1'b1;
    end
    if (uncorr_nmi) begin
      nmiv_d = FBE_NMI_UNCOR;
      irqs_d[FBE_IRQ_NMI] = 1'b1;
    end else if (corr_nmi) begin
      nmiv_d = FBE_NMI_CORR;
      irqs_d[FBE_IRQ_NMI] = 1'b1;
    end
    // The phantom-error window runs from wake until a real memory access completes.
    if (wake_pulse) begin
      wake_d = 1'b1;
    end else if (mem_access_done) begin
      wake_d = 1'b0;
    end
  end

  // Response pulses are their events delayed by one cycle, high as long as the events are.
  assign rst_d = uncorr_rst | silent_rst;
  assign nmi_d = uncorr_nmi | corr_nmi;

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q  <= FBE_BUS_IDLE;
      rdat_q <= 32'h0;
      ctrl_q <= FBE_CTRL_RST;
      flag_q <= 2'h0;
      rstv_q <= FBE_VEC_NONE;
      nmiv_q <= FBE_VEC_NONE;
      irqs_q <= 4'h0;
      irqm_q <= 4'h0;
      wake_q <= 1'b0;
      rst_q  <= 1'b0;
      nmi_q  <= 1'b0;
    end else begin
      bus_q  <= bus_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      rstv_q <= rstv_d;
      nmiv_q <= nmiv_d;
      irqs_q <= irqs_d;
      irqm_q <= irqm_d;
      wake_q <= wake_d;
      rst_q  <= rst_d;
      nmi_q  <= nmi_d;
    end
  end

  // Outputs all come straight from flip-flops except the ack state decode and the mask gate.
  assign wb_ack_o           = (bus_q == FBE_BUS_ACK);
  assign wb_dat_o           = rdat_q;
  assign warm_system_reset  = rst_q;
  assign nmi_req            = nmi_q;
  assign reset_cause_vector = rstv_q;
  assign system_nmi_vector  = nmiv_q;
  assign irq                = |(irqs_q & irqm_q);

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_real_uncorr;
    uncorr_det && uncorr_err_reset_en;
  endsequence
  sequence s_recorded_reset;
    warm_system_reset && reset_cause_vector == FBE_RST_UNCOR;
  endsequence

  a_uncorr_reset_cause: assert property (s_real_uncorr |=> s_recorded_reset)
    else $error("Uncorrectable error did not give recorded reset.");
  a_no_reset_disabled: assert property (!uncorr_err_reset_en |=> !warm_system_reset)
    else $error("Warm reset issued while reset enable low.");
  a_uncorr_nmi_vec: assert property (uncorr_det && uncorr_err_irq_en && uncorr_err_reset_en
    |=> nmi_req && system_nmi_vector == FBE_NMI_UNCOR)
    else $error("Uncorrectable NMI missing or wrong vector.");
  a_corr_nmi_vec: assert property (corr_det && corr_err_irq_en && !uncorr_ev
    |=> nmi_req && system_nmi_vector == FBE_NMI_CORR)
    else $error("Correctable NMI missing or wrong vector.");
  a_silent_no_trace: assert property (silent_rst && !uncorr_ev && !uncorr_det
    |=> warm_system_reset && reset_cause_vector == FBE_VEC_NONE)
    else $error("Spurious reset left a cause value.");
  a_silent_slow_clk: assert property (!mclk_fast && !uncorr_ev |=> !warm_system_reset)
    else $error("Reset without error at slow clock.");
  a_no_uncorr_nmi: assert property (MODEL_DEFECTS && !uncorr_err_reset_en && !corr_det
    |=> !nmi_req)
    else $error("NMI raised while reset enable low.");
  a_flag_sticky: assert property (flag_q[FBE_FLAG_UNCORR] && !bus_wr
    |=> flag_q[FBE_FLAG_UNCORR])
    else $error("Uncorrectable flag dropped without a clear.");
  a_flag_set: assert property (uncorr_det |=> flag_q[FBE_FLAG_UNCORR][*2]
    or (flag_q[FBE_FLAG_UNCORR] ##1 $past(bus_wr)))
    else $error("Uncorrectable flag not set on detection.");
  a_wake_phantom: assert property (MODEL_DEFECTS && wake_q && glitch_det
    |=> flag_q[FBE_FLAG_UNCORR])
    else $error("Post-wake phantom error not flagged.");

endmodule : fbe_responder

// >>> rtl/fbe_pkg.sv
// Package with register map, field positions and cause codes of the memory error responder.
package fbe_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the Wishbone bus.
  // ----------------------------------------------------------------
  localparam logic [4:0] FBE_ADDR_CTRL  = 5'h00; // Error response enables.
  localparam logic [4:0] FBE_ADDR_FLAG  = 5'h04; // Sticky error flags, write one to clear.
  localparam logic [4:0] FBE_ADDR_RSTV  = 5'h08; // Reset cause vector, any write clears.
  localparam logic [4:0] FBE_ADDR_NMIV  = 5'h0c; // System NMI vector, any write clears.
  localparam logic [4:0] FBE_ADDR_IRQS  = 5'h10; // Interrupt status, write one to clear.
  localparam logic [4:0] FBE_ADDR_IRQM  = 5'h14; // Interrupt mask, one enables.
  localparam logic [4:0] FBE_ADDR_STAT  = 5'h18; // Live state, read only.

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int FBE_CTRL_RST_EN   = 0; // Uncorrectable error warm reset enable.
  localparam int FBE_CTRL_UIRQ_EN  = 1; // Uncorrectable error NMI enable.
  localparam int FBE_CTRL_CIRQ_EN  = 2; // Correctable error NMI enable.
  localparam int FBE_FLAG_UNCORR   = 0; // Uncorrectable error flag.
  localparam int FBE_FLAG_CORR     = 1; // Correctable error flag.
  localparam int FBE_IRQ_UNCORR    = 0; // Uncorrectable error seen.
  localparam int FBE_IRQ_CORR      = 1; // Correctable error seen.
  localparam int FBE_IRQ_RESET     = 2; // Warm reset requested.
  localparam int FBE_IRQ_NMI       = 3; // NMI requested.
  localparam int FBE_IRQ_W         = 4; // Width of the interrupt registers.

  // ----------------------------------------------------------------
  // Reset values and recorded cause codes.
  // ----------------------------------------------------------------
  localparam logic [2:0] FBE_CTRL_RST  = 3'h0;
  localparam logic [7:0] FBE_VEC_NONE  = 8'h00; // No identifiable source.
  localparam logic [7:0] FBE_RST_UNCOR = 8'h1a; // Cause of an uncorrectable error reset.
  localparam logic [7:0] FBE_NMI_UNCOR = 8'h02; // NMI cause of an uncorrectable error.
  localparam logic [7:0] FBE_NMI_CORR  = 8'h04; // NMI cause of a correctable error.

  // Bus handshake state, one-hot.
  typedef enum logic [1:0] {
    FBE_BUS_IDLE = 2'b01,
    FBE_BUS_ACK  = 2'b10
  } fbe_bus_t;

endpackage : fbe_pkg

// >>> verification/fbe_sys_ctrl_model.sv
// Behavioural reset and NMI controller that tallies the responder's requests.
`timescale 1ns/1ps
module fbe_sys_ctrl_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Requests from the responder.
  input  wire logic       warm_system_reset,
  input  wire logic       nmi_req,
  input  wire logic [7:0] reset_cause_vector,
  // Tallies for the bench.
  output int              rst_seen,
  output int              nmi_seen,
  output int              ign_seen
);
  // ----
  // Request tally
  // ----
  // Each clock edge with a request high counts once, so a request held for several cycles counts once per cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_seen <= 0;
      nmi_seen <= 0;
      ign_seen <= 0;
    end else begin
      rst_seen <= rst_seen + int'(warm_system_reset);
      nmi_seen <= nmi_seen + int'(nmi_req);
      // A reset whose cause reads zero is treated as spurious and ignored.
      ign_seen <= ign_seen + int'(warm_system_reset && reset_cause_vector == 8'h00);
    end
  end
endmodule : fbe_sys_ctrl_model

// >>> verification/fram_bit_error_response_test.sv
// Self-checking bench of the memory error responder with a reset controller model.
`timescale 1ns/1ps
module fram_bit_error_response_test;
  import fbe_pkg::*;
  // ----
  // Signals
  // ----
  logic        ref_clk, arst_n, cyc, stb, we, ack, ud, cd, gd, fast, wake, mdone;
  logic        wrst, nmi, irq;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [7:0]  rcv, nmv;
  int          rst_seen, nmi_seen, ign_seen, miscompares, checks_done;

  fbe_responder uut (.ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .uncorr_det(ud), .corr_det(cd), .glitch_det(gd), .mclk_fast(fast),
    .wake_pulse(wake), .mem_access_done(mdone), .warm_system_reset(wrst), .nmi_req(nmi),
    .reset_cause_vector(rcv), .system_nmi_vector(nmv), .irq(irq));
  fbe_sys_ctrl_model ctl (.ref_clk(ref_clk), .arst_n(arst_n), .warm_system_reset(wrst),
    .nmi_req(nmi), .reset_cause_vector(rcv), .rst_seen(rst_seen), .nmi_seen(nmi_seen),
    .ign_seen(ign_seen));

  // 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----
  // Shared tasks
  // ----
  // Counts a comparison and reports a difference at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle; the wait is bounded because the slave may hang.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // A slave that never answers ends the run through the one closing task.
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      test_done;
    end
    rd = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : bus
  // Clears flags, vectors and status so every event starts clean.
  task clr;
    bus(1'b1, FBE_ADDR_FLAG, 32'h3);
    bus(1'b1, FBE_ADDR_RSTV, 32'h0);
    bus(1'b1, FBE_ADDR_NMIV, 32'h0);
    bus(1'b1, FBE_ADDR_IRQS, 32'hf);
  endtask : clr
  // Pulses {glitch, corr, uncorr} and checks request tallies and vectors.
  task ev(input logic [2:0] e, input int er, input int en, input logic [7:0] ec, ev_nmi);
    int r0, n0;
    r0 = rst_seen;
    n0 = nmi_seen;
    @(posedge ref_clk);
    {gd, cd, ud} <= e;
    @(posedge ref_clk);
    {gd, cd, ud} <= 3'h0;
    @(posedge ref_clk);
    #1;
    chk(32'(rst_seen - r0), 32'(er));
    chk(32'(nmi_seen - n0), 32'(en));
    chk({24'h0, rcv}, {24'h0, ec});
    chk({24'h0, nmv}, {24'h0, ev_nmi});
  endtask : ev
  // Pulses wake (m=1) or first memory access done (m=0).
  task pls(input logic m);
    @(posedge ref_clk);
    {wake, mdone} <= {m, !m};
    @(posedge ref_clk);
    {wake, mdone} <= 2'b00;
  endtask : pls
  // ----
  // Scenarios
  // ----
  // Every register, and one unmapped place, reads zero after reset.
  task t_reset;
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_reset
  // Enabled and disabled uncorrectable responses; flag stays until cleared.
  task t_uncorr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h3);
    ev(3'h1, 1, 1, FBE_RST_UNCOR, FBE_NMI_UNCOR);
    bus(1'b0, FBE_ADDR_FLAG, 32'h0);
    chk(rd, 32'h1);
    clr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h2);
    ev(3'h1, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    bus(1'b1, FBE_ADDR_CTRL, 32'h0);
    ev(3'h1, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    bus(1'b0, FBE_ADDR_FLAG, 32'h0);
    chk(rd, 32'h1);
  endtask : t_uncorr
  // Correctable events with the interrupt enable on and off.
  task t_corr;
    clr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h4);
    ev(3'h2, 0, 1, FBE_VEC_NONE, FBE_NMI_CORR);
    clr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h0);
    ev(3'h2, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    bus(1'b0, FBE_ADDR_FLAG, 32'h0);
    chk(rd, 32'h2);
  endtask : t_corr
  // Spurious reset at a fast main clock: no cause, no flag, ignored by the controller model.
  task t_glitch;
    int i0;
    clr;
    i0 = ign_seen;
    bus(1'b1, FBE_ADDR_CTRL, 32'h1);
    fast <= 1'b1;
    ev(3'h4, 1, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    chk(32'(ign_seen - i0), 32'h1);
    bus(1'b0, FBE_ADDR_FLAG, 32'h0);
    chk(rd, 32'h0);
    fast <= 1'b0;
    ev(3'h4, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    // Workaround at a fast clock: with the reset enable low the glitch is harmless.
    fast <= 1'b1;
    bus(1'b1, FBE_ADDR_CTRL, 32'h0);
    ev(3'h4, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    fast <= 1'b0;
  endtask : t_glitch
  // Phantom error after wake, then the same wake with the software workaround.
  task t_wake;
    clr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h7);
    pls(1'b1);
    ev(3'h4, 1, 1, FBE_RST_UNCOR, FBE_NMI_UNCOR);
    pls(1'b0);
    bus(1'b0, FBE_ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    clr;
    bus(1'b1, FBE_ADDR_CTRL, 32'h0);
    pls(1'b1);
    bus(1'b0, FBE_ADDR_STAT, 32'h0);
    chk(rd, 32'h1);
    ev(3'h4, 0, 0, FBE_VEC_NONE, FBE_VEC_NONE);
    bus(1'b1, FBE_ADDR_FLAG, 32'h3);
    bus(1'b0, FBE_ADDR_FLAG, 32'h0);
    chk(rd, 32'h0);
    pls(1'b0);
    bus(1'b1, FBE_ADDR_CTRL, 32'h7);
  endtask : t_wake
  // Status, mask and write-one-to-clear of the level interrupt.
  task t_irq;
    clr;
    bus(1'b1, FBE_ADDR_IRQM, 32'h0);
    bus(1'b1, FBE_ADDR_CTRL, 32'h1);
    ev(3'h1, 1, 0, FBE_RST_UNCOR, FBE_VEC_NONE);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, FBE_ADDR_IRQS, 32'h0);
    chk(rd, 32'h5);
    bus(1'b1, FBE_ADDR_IRQM, 32'h5);
    #1 chk({31'h0, irq}, 32'h1);
    bus(1'b1, FBE_ADDR_IRQS, 32'h5);
    #1 chk({31'h0, irq}, 32'h0);
  endtask : t_irq
  // ----
  // Run control
  // ----
  // The single place where the run ends.
  task test_done;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // The whole run takes a few hundred cycles; this bound catches a hang.
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    {arst_n, cyc, stb, we, ud, cd, gd, fast, wake, mdone} = '0;
    {adr, wdat, sel} = {5'h0, 32'h0, 4'hf};
    {miscompares, checks_done} = '0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_uncorr;
    t_corr;
    t_glitch;
    t_wake;
    t_irq;
    test_done;
  end
endmodule : fram_bit_error_response_test
